// File: core/gpio_port_defines.svh
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// port geometry
`define GPIO_PORT_WIDTH   8
`define GPIO_BIT_SEL_W    3
`define GPIO_ADDR_W       2

// location of each port register in the i/o space window
`define GPIO_OFS_PIN_IN   2'h0
`define GPIO_OFS_DIR      2'h1
`define GPIO_OFS_OUT      2'h2

// reset values, plus the zero byte and the one-hot seed of the bit-op mask
`define GPIO_RST_OUT      8'h00
`define GPIO_RST_DIR      8'h00
`define GPIO_RST_SYNC     8'h00
`define GPIO_RST_RDATA    8'h00
`define GPIO_ZERO_BYTE    8'h00
`define GPIO_ONE_HOT_LSB  8'h01

`endif

// File: core/gpio_port_pkg.sv
`include "gpio_port_defines.svh"

package gpio_port_pkg;

  // one byte of port state, one bit per pin
  typedef logic [`GPIO_PORT_WIDTH-1:0] port_byte_t;

  // kind of access presented on the i/o port in a cycle
  typedef enum logic [1:0] {
    op_none,
    op_byte_write,
    op_bit_set,
    op_bit_clear
  } io_op_e;

  // pin configuration as seen from {dir, out, pullup_off}
  typedef enum logic [1:0] {
    mode_hi_z,
    mode_pullup_in,
    mode_drive_low,
    mode_drive_high
  } pin_mode_e;

endpackage : gpio_port_pkg

// File: core/pin_ctrl_if.sv
`timescale 1ns/10ps
`default_nettype none

// next-state pin controls from the register file to the pad and input stage
interface pin_ctrl_if;
  gpio_port_pkg::port_byte_t dir_next;
  gpio_port_pkg::port_byte_t out_next;
  logic                      pullup_off;
  logic                      sleep_clamp;
  gpio_port_pkg::port_byte_t ext_int_en;

  modport ctrl (
    output dir_next,
    output out_next,
    output pullup_off,
    output sleep_clamp,
    output ext_int_en
  );

  modport pad (
    input dir_next,
    input out_next,
    input pullup_off,
    input sleep_clamp,
    input ext_int_en
  );
endinterface : pin_ctrl_if

`default_nettype wire

// File: core/pin_pad.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_defines.svh"

module pin_pad (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // controls
  pin_ctrl_if.pad                        ctrl,
  // pad drive
  output var  gpio_port_pkg::port_byte_t pin_o_q,
  output var  gpio_port_pkg::port_byte_t pin_oe_q,
  output var  gpio_port_pkg::port_byte_t pullup_en_q
);

  gpio_port_pkg::port_byte_t pullup_d;

  // each pin has its own pull-up term, no sharing between pins
  for (genvar i = 0; i < `GPIO_PORT_WIDTH; i++) begin : g_pu
    assign pullup_d[i] = ~ctrl.dir_next[i] & ctrl.out_next[i]
                         & ~ctrl.pullup_off;
  end

  // async clear: pins float the moment reset falls, clock or not
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe_q    <= `GPIO_ZERO_BYTE;
      pin_o_q     <= `GPIO_ZERO_BYTE;
      pullup_en_q <= `GPIO_ZERO_BYTE;
    end else begin
      pin_oe_q    <= ctrl.dir_next;
      pin_o_q     <= ctrl.out_next;
      pullup_en_q <= pullup_d;
    end
  end

endmodule : pin_pad

`default_nettype wire

// File: core/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_defines.svh"

module pin_sync (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // controls and raw pad level
  pin_ctrl_if.pad                        ctrl,
  input  wire gpio_port_pkg::port_byte_t pin_i,
  // synchronised level
  output var  gpio_port_pkg::port_byte_t sync_q
);

  gpio_port_pkg::port_byte_t din;
  gpio_port_pkg::port_byte_t latch_q;

  // deep sleep grounds the input unless the pin serves an ext interrupt
  assign din = pin_i & ~({`GPIO_PORT_WIDTH{ctrl.sleep_clamp}}
                         & ~ctrl.ext_int_en);

  // half-cycle latch: open while clk high, holds through the low phase;
  // nonblocking so the rising-edge register still takes the held value
  always_latch begin
    if (clk) begin
      latch_q <= din;
    end
  end

  // second stage takes the held value at the next rising edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= `GPIO_RST_SYNC;
    end else begin
      sync_q <= latch_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// File: core/general_digital_io_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_defines.svh"

module general_digital_io_port (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  // i/o space access from the processor core
  input  wire logic [`GPIO_ADDR_W-1:0]         io_addr,
  input  wire logic                            io_we,
  input  wire logic                            io_re,
  input  wire logic                            io_bit_set,
  input  wire logic                            io_bit_clr,
  input  wire logic [`GPIO_BIT_SEL_W-1:0]      io_bit_sel,
  input  wire gpio_port_pkg::port_byte_t       io_wdata,
  output var  gpio_port_pkg::port_byte_t       io_rdata_q,
  // chip-wide controls from the core
  input  wire logic                            global_pullup_off,
  input  wire logic                            sleep_deep,
  input  wire gpio_port_pkg::port_byte_t       ext_int_en,
  // pads
  input  wire gpio_port_pkg::port_byte_t       pin_i,
  output var  gpio_port_pkg::port_byte_t       pin_o,
  output var  gpio_port_pkg::port_byte_t       pin_oe,
  output var  gpio_port_pkg::port_byte_t       pullup_en
);

  gpio_port_pkg::port_byte_t port_output_data_q;
  gpio_port_pkg::port_byte_t port_output_data_d;
  gpio_port_pkg::port_byte_t port_direction_q;
  gpio_port_pkg::port_byte_t port_direction_d;
  gpio_port_pkg::port_byte_t port_pin_input;
  gpio_port_pkg::port_byte_t bit_mask;
  gpio_port_pkg::port_byte_t rdata_d;
  gpio_port_pkg::io_op_e     op;
  logic                      hit_out;
  logic                      hit_dir;
  logic                      hit_pin;

  pin_ctrl_if ctrl_bus ();

  // address decode; unused code 3 selects nothing
  assign hit_out = (io_addr == `GPIO_OFS_OUT);
  assign hit_dir = (io_addr == `GPIO_OFS_DIR);
  assign hit_pin = (io_addr == `GPIO_OFS_PIN_IN);

  // a byte write outranks a bit op offered in the same cycle
  assign op = io_we      ? gpio_port_pkg::op_byte_write :
              io_bit_set ? gpio_port_pkg::op_bit_set    :
              io_bit_clr ? gpio_port_pkg::op_bit_clear  :
                           gpio_port_pkg::op_none;

  // one-hot mask so a bit op can never disturb neighbouring pins
  assign bit_mask = `GPIO_ONE_HOT_LSB << io_bit_sel;

  // next value of a writable register under the current op
  function automatic gpio_port_pkg::port_byte_t next_val(
    input gpio_port_pkg::port_byte_t cur,
    input logic                      hit,
    input gpio_port_pkg::io_op_e     kind,
    input gpio_port_pkg::port_byte_t wdata,
    input gpio_port_pkg::port_byte_t mask
  );
    gpio_port_pkg::port_byte_t res;
    res = cur;
    if (hit) begin
      case (kind)
        gpio_port_pkg::op_byte_write: res = wdata;
        gpio_port_pkg::op_bit_set:    res = cur | mask;
        gpio_port_pkg::op_bit_clear:  res = cur & ~mask;
        default:                      res = cur;
      endcase
    end
    return res;
  endfunction : next_val

  // the pin input location has no write path at all
  assign port_output_data_d = next_val(port_output_data_q, hit_out, op,
                                       io_wdata, bit_mask);
  assign port_direction_d   = next_val(port_direction_q, hit_dir, op,
                                       io_wdata, bit_mask);

  // register file
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_output_data_q <= `GPIO_RST_OUT;
      port_direction_q   <= `GPIO_RST_DIR;
    end else begin
      port_output_data_q <= port_output_data_d;
      port_direction_q   <= port_direction_d;
    end
  end

  // pads see the next values so a write reaches the pin at its own edge;
  // going hi-z to drive-high needs two writes, so a middle state shows
  assign ctrl_bus.dir_next    = port_direction_d;
  assign ctrl_bus.out_next    = port_output_data_d;
  assign ctrl_bus.pullup_off  = global_pullup_off;
  assign ctrl_bus.sleep_clamp = sleep_deep;
  assign ctrl_bus.ext_int_en  = ext_int_en;

  pin_pad u_pad (
    .clk         (clk),
    .reset_n     (reset_n),
    .ctrl        (ctrl_bus.pad),
    .pin_o_q     (pin_o),
    .pin_oe_q    (pin_oe),
    .pullup_en_q (pullup_en)
  );

  // pad level is sampled whatever the direction, so outputs read back
  pin_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ctrl    (ctrl_bus.pad),
    .pin_i   (pin_i),
    .sync_q  (port_pin_input)
  );

  // read mux; unmapped location reads zero
  assign rdata_d = hit_out ? port_output_data_q :
                   hit_dir ? port_direction_q   :
                   hit_pin ? port_pin_input     :
                             `GPIO_ZERO_BYTE;

  // read data registered; holds between reads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_q <= `GPIO_RST_RDATA;
    end else if (io_re) begin
      io_rdata_q <= rdata_d;
    end
  end

endmodule : general_digital_io_port

`default_nettype wire

// File: sim/gpio_port_sva.sv
`timescale 1ns/10ps
`default_nettype none

module gpio_port_sva (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      reset_n,
  // register port
  input wire logic [1:0]                io_addr,
  input wire logic                      io_we,
  input wire logic                      io_re,
  input wire logic                      io_bit_set,
  input wire logic                      io_bit_clr,
  input wire logic [2:0]                io_bit_sel,
  input wire gpio_port_pkg::port_byte_t io_wdata,
  input wire gpio_port_pkg::port_byte_t io_rdata_q,
  // chip controls and pads
  input wire logic                      global_pullup_off,
  input wire logic                      sleep_deep,
  input wire gpio_port_pkg::port_byte_t ext_int_en,
  input wire gpio_port_pkg::port_byte_t pin_i,
  input wire gpio_port_pkg::port_byte_t pin_o,
  input wire gpio_port_pkg::port_byte_t pin_oe,
  input wire gpio_port_pkg::port_byte_t pullup_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // decoded requests; bit_m is the single pin a set or clear may touch
  wire gpio_port_pkg::port_byte_t bit_m = 8'h01 << io_bit_sel;
  wire                            dir_w = io_we && io_addr == 2'h1;
  wire                            out_w = io_we && io_addr == 2'h2;

  a_dir_write: assert property (
    dir_w |=> pin_oe == $past(io_wdata)) else $error("pin_oe missed write");
  a_out_write: assert property (
    out_w |=> pin_o == $past(io_wdata)) else $error("pin_o missed write");
  a_pullup_eq: assert property (
    pullup_en == (~pin_oe & pin_o & {8{!$past(global_pullup_off)}}))
    else $error("pull-up enable wrong");
  a_reset_float: assert property (disable iff (1'b0)
    !reset_n |-> pin_oe == 8'h00 && pullup_en == 8'h00)
    else $error("pins not floating in reset");
  a_bit_set: assert property (
    io_bit_set && !io_we && io_addr == 2'h1
    |=> pin_oe == ($past(pin_oe) | $past(bit_m))) else $error("bit set");
  a_bit_clr: assert property (
    io_bit_clr && !io_we && !io_bit_set && io_addr == 2'h2
    |=> pin_o == ($past(pin_o) & ~$past(bit_m))) else $error("bit clear");
  a_pin_in_ro: assert property (
    io_addr == 2'h0 |=> $stable(pin_oe) && $stable(pin_o))
    else $error("pin input location written");
  a_read_dir: assert property (
    io_re && io_addr == 2'h1 |=> io_rdata_q == $past(pin_oe))
    else $error("direction read wrong");
  a_rdata_hold: assert property (
    !io_re |=> $stable(io_rdata_q)) else $error("read data moved");
  a_sleep_clamp: assert property (
    sleep_deep && $past(sleep_deep) && io_re && io_addr == 2'h0
    |=> (io_rdata_q & ~$past(ext_int_en) & ~$past(ext_int_en, 2)) == 8'h00)
    else $error("sleep clamp leaked");
  a_two_step: assert property (
    ((pin_oe ^ $past(pin_oe)) & (pin_o ^ $past(pin_o))) == 8'h00)
    else $error("pin changed direction and value at once");

  // main scenarios reached
  c_bit_set: cover property (io_bit_set && io_addr == 2'h1);
  c_pin_read: cover property (io_re && io_addr == 2'h0);
  c_sleep_read: cover property (sleep_deep && io_re);
endmodule : gpio_port_sva

`default_nettype wire

// File: sim/pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module pad_model (
  // clock
  input  wire logic                      clk,
  // device pad drive
  input  wire gpio_port_pkg::port_byte_t pin_o,
  input  wire gpio_port_pkg::port_byte_t pin_oe,
  input  wire gpio_port_pkg::port_byte_t pullup_en,
  // far-side driver
  input  wire gpio_port_pkg::port_byte_t ext_val,
  input  wire gpio_port_pkg::port_byte_t ext_en,
  // level seen by the device
  output var  gpio_port_pkg::port_byte_t pin_i
);
  gpio_port_pkg::port_byte_t float_q = 8'h55;

  // an undriven, unpulled line wanders, so a stale level never passes
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // device driver wins, then far side, then pull-up, else floating
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & (pullup_en | float_q));
endmodule : pad_model

`default_nettype wire

// File: sim/general_digital_io_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

module general_digital_io_port_tb;
  logic                      clk = 0, reset_n, io_we = 0, io_re = 0;
  logic                      io_bit_set = 0, io_bit_clr = 0;
  logic                      global_pullup_off = 0, sleep_deep = 0;
  logic [1:0]                io_addr = 0, a;
  logic [2:0]                io_bit_sel = 0, s;
  logic [3:0]                k;
  gpio_port_pkg::port_byte_t io_wdata = 0, ext_int_en = 0, ext_val = 0;
  gpio_port_pkg::port_byte_t ext_en = 8'hff, d, dir_m = 0, out_m = 0;
  gpio_port_pkg::port_byte_t io_rdata_q, pin_i, pin_o, pin_oe, pullup_en;
  int                        fail_count = 0, cmp_count = 0, seed = 3, cyc = 0;

  general_digital_io_port general_digital_io_port_inst (.clk, .reset_n,
    .io_addr, .io_we, .io_re, .io_bit_set, .io_bit_clr, .io_bit_sel,
    .io_wdata, .io_rdata_q, .global_pullup_off, .sleep_deep, .ext_int_en,
    .pin_i, .pin_o, .pin_oe, .pullup_en);
  pad_model pad_model_inst (.clk, .pin_o, .pin_oe, .pullup_en, .ext_val,
    .ext_en, .pin_i);

  // 100 MHz clock
  always #5 clk = ~clk;

  task chk(input gpio_port_pkg::port_byte_t got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // k is {write, set, clear, read}; taken at the next edge
  task op(input logic [1:0] ad, input logic [3:0] kk,
          input gpio_port_pkg::port_byte_t dd, input logic [2:0] ss);
    {io_we, io_bit_set, io_bit_clr, io_re} = kk;
    io_addr = ad;
    io_wdata = dd;
    io_bit_sel = ss;
    @(posedge clk);
    #1;
  endtask : op

  function automatic gpio_port_pkg::port_byte_t nxt(
    gpio_port_pkg::port_byte_t c, logic hit, logic [3:0] kk,
    gpio_port_pkg::port_byte_t dd, logic [2:0] ss);
    if (!hit) return c;
    if (kk[3]) return dd;
    if (kk[2]) return c | (8'h01 << ss);
    if (kk[1]) return c & ~(8'h01 << ss);
    return c;
  endfunction : nxt

  function automatic gpio_port_pkg::port_byte_t exp_rd(logic [1:0] ad);
    case (ad)
      2'h0: return (dir_m & out_m) | (~dir_m & ext_val);
      2'h1: return dir_m;
      2'h2: return out_m;
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    // x to 0 is a real falling edge, so the async clear acts at once
    reset_n = 0;
    repeat (5) @(posedge clk);
    #1;
    chk(pin_oe | pullup_en, 8'h00);
    reset_n = 1;
    op(2'h1, 4'b0001, 8'h00, 3'h0);
    chk(io_rdata_q, 8'h00);
    // random writes, set, clear on every location; idle cycle before read
    repeat (60) begin
      k = 4'b1000 >> ($unsigned($random(seed)) % 3);
      a = 2'($random(seed));
      d = 8'($random(seed));
      s = 3'($random(seed));
      ext_val = 8'($random(seed));
      global_pullup_off = 1'($random(seed));
      dir_m = nxt(dir_m, a == 2'h1, k, d, s);
      out_m = nxt(out_m, a == 2'h2, k, d, s);
      op(a, k, d, s);
      chk(pin_oe, dir_m);
      chk(pin_o, out_m);
      chk(pullup_en, ~dir_m & out_m & {8{~global_pullup_off}});
      op(a, 4'b0000, d, s);
      op(a, 4'b0001, d, s);
      chk(io_rdata_q, exp_rd(a));
    end
    // write outranks set, set outranks clear
    op(2'h2, 4'b1100, 8'h5a, 3'h0);
    chk(pin_o, 8'h5a);
    op(2'h2, 4'b0110, 8'h00, 3'h7);
    chk(pin_o, 8'hda);
    // pulled-up inputs read high with nothing else driving
    ext_en = 8'h00;
    global_pullup_off = 0;
    op(2'h1, 4'b1000, 8'h00, 3'h0);
    op(2'h2, 4'b1000, 8'hff, 3'h0);
    op(2'h0, 4'b0000, 8'h00, 3'h0);
    op(2'h0, 4'b0001, 8'h00, 3'h0);
    chk(io_rdata_q, 8'hff);
    // deep sleep clamps all but interrupt pins
    ext_en = 8'hff;
    ext_val = 8'hff;
    sleep_deep = 1;
    ext_int_en = 8'h0f;
    op(2'h0, 4'b0000, 8'h00, 3'h0);
    op(2'h0, 4'b0001, 8'h00, 3'h0);
    op(2'h0, 4'b0001, 8'h00, 3'h0);
    chk(io_rdata_q, 8'h0f);
    sleep_deep = 0;
    // reset in mid-run floats the pins before any edge
    op(2'h1, 4'b1000, 8'hff, 3'h0);
    #2;
    reset_n = 0;
    #1;
    chk(pin_oe | pullup_en, 8'h00);
    complete_run();
  end
endmodule : general_digital_io_port_tb

bind general_digital_io_port gpio_port_sva gpio_port_sva_inst (.clk,
  .reset_n, .io_addr, .io_we, .io_re, .io_bit_set, .io_bit_clr, .io_bit_sel,
  .io_wdata, .io_rdata_q, .global_pullup_off, .sleep_deep, .ext_int_en,
  .pin_i, .pin_o, .pin_oe, .pullup_en);

`default_nettype wire
